// file: smp_defs.svh
// Constants of the serial host port of the multiplexed analog input module.
//
// Operation
// - The module receives the controller's serial stream on the serial-in line.
// - The module returns its serial answer on the serial-out line.
// - The data-or-address line marks each incoming bit as address or data, and the module treats it so.
// - The active-low slot-select line sends traffic to slot zero when low, and the module then ignores it.
// - Each rising edge of the scan clock advances the channel multiplexer by one source, unless a data-byte channel load lands in the same cycle and wins.
// - The controller supplies the serial clock that times both serial lines.
// - The multiplexer walks 32 input channels plus the cold-junction sensor onto one output channel.
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

`define SMP_BYTE_W 8
`define SMP_CHAN_W 6
`define SMP_BIT_LAST 3'h7
`define SMP_CHAN_FIRST 6'h00
`define SMP_CHAN_INPUTS 6'h20
`define SMP_CHAN_COLD_JUNCTION 6'h20
`define SMP_MODULE_ADDR 8'h01
`define SMP_BUF_W 8

`endif

// file: smp_pkg.sv
// Types shared by the serial host port design.
`include "smp_defs.svh"
package smp_pkg;

  typedef enum logic [2:0] {
    SMP_IDLE = 3'b001,
    SMP_ADDR = 3'b010,
    SMP_DATA = 3'b100
  } smp_phase_type;

  typedef struct packed {
    logic mosi_s1;
    logic mosi_s2;
    logic da_s1;
    logic da_s2;
    logic sel_s1;
    logic sel_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic scan_s1;
    logic scan_s2;
    logic scan_d;
    smp_phase_type phase;
    logic [2:0] bit_cnt;
    logic [`SMP_BYTE_W-1:0] shift_in;
    logic [`SMP_BYTE_W-1:0] shift_out;
    logic selected;
    logic [`SMP_CHAN_W-1:0] channel;
    logic miso;
    logic miso_oe;
    logic pend_valid;
    logic [`SMP_BYTE_W-1:0] pend_data;
    logic overrun;
  } smp_state_type;

endpackage

// file: smp_buf.sv
// Two-entry buffer with valid and ready on both sides and registered outputs.
`timescale 1ns/1ps
`include "smp_defs.svh"
module smp_buf #(
  parameter int WIDTH = `SMP_BUF_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic head_v;
    logic [WIDTH-1:0] head_d;
    logic tail_v;
    logic [WIDTH-1:0] tail_d;
  } smp_buf_state_type;

  smp_buf_state_type st_reg;
  smp_buf_state_type st_next;
  logic pop;
  logic push;

  // Ready depends only on the tail flag, so no path runs from out_ready to in_ready.
  assign in_ready = ~st_reg.tail_v;
  assign out_valid = st_reg.head_v;
  assign out_data = st_reg.head_d;
  assign pop = st_reg.head_v & out_ready;
  assign push = in_valid & ~st_reg.tail_v;

  always_comb begin
    st_next = st_reg;
    if (pop) begin
      if (st_reg.tail_v) begin
        st_next.head_d = st_reg.tail_d;
        st_next.tail_v = 1'b0;
      end else begin
        st_next.head_v = 1'b0;
      end
    end
    if (push) begin
      if (!st_next.head_v) begin
        st_next.head_v = 1'b1;
        st_next.head_d = in_data;
      end else begin
        st_next.tail_v = 1'b1;
        st_next.tail_d = in_data;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: smp_port.sv
// Serial host port and channel sequencer of the multiplexed analog input module.
`timescale 1ns/1ps
`include "smp_defs.svh"
module smp_port
  import smp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  input wire logic data_or_address_line,
  input wire logic slot_zero_select_n,
  input wire logic serial_shift_clock,
  input wire logic scan_advance_clock,
  output logic [`SMP_CHAN_W-1:0] channel_select,
  output logic module_selected,
  output logic [`SMP_BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun
);

  smp_state_type st_reg;
  smp_state_type st_next;
  smp_phase_type phase_now;
  logic sck_rise;
  logic sck_fall;
  logic scan_rise;
  logic byte_done;
  logic addr_done;
  logic data_done;
  logic data_load;
  logic buf_in_ready;
  logic [`SMP_BYTE_W-1:0] byte_now;
  logic [`SMP_CHAN_W-1:0] chan_inc;

  // Edges are taken only from the second synchroniser stage and its delayed copy.
  assign sck_rise = st_reg.sck_s2 & ~st_reg.sck_d;
  assign sck_fall = ~st_reg.sck_s2 & st_reg.sck_d;
  assign scan_rise = st_reg.scan_s2 & ~st_reg.scan_d;

  always_comb begin
    // Slot zero traffic is never ours; otherwise the marker line picks address or data.
    if (!st_reg.sel_s2) begin
      phase_now = SMP_IDLE;
    end else if (st_reg.da_s2) begin
      phase_now = SMP_ADDR;
    end else begin
      phase_now = SMP_DATA;
    end
  end

  assign byte_now = {st_reg.shift_in[`SMP_BYTE_W-2:0], st_reg.mosi_s2};
  assign byte_done = sck_rise && (st_reg.bit_cnt == `SMP_BIT_LAST) && (phase_now == st_reg.phase);
  assign addr_done = byte_done && (st_reg.phase == SMP_ADDR);
  assign data_done = byte_done && (st_reg.phase == SMP_DATA) && st_reg.selected;
  assign data_load = data_done && (byte_now[`SMP_CHAN_W-1:0] <= `SMP_CHAN_COLD_JUNCTION)
    && (byte_now[`SMP_BYTE_W-1:`SMP_CHAN_W] == 2'h0);
  assign chan_inc = (st_reg.channel == `SMP_CHAN_COLD_JUNCTION) ? `SMP_CHAN_FIRST
    : st_reg.channel + 6'h01;

  always_comb begin
    st_next = st_reg;
    st_next.mosi_s1 = serial_in_line;
    st_next.mosi_s2 = st_reg.mosi_s1;
    st_next.da_s1 = data_or_address_line;
    st_next.da_s2 = st_reg.da_s1;
    st_next.sel_s1 = slot_zero_select_n;
    st_next.sel_s2 = st_reg.sel_s1;
    st_next.sck_s1 = serial_shift_clock;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_d = st_reg.sck_s2;
    st_next.scan_s1 = scan_advance_clock;
    st_next.scan_s2 = st_reg.scan_s1;
    st_next.scan_d = st_reg.scan_s2;
    st_next.overrun = 1'b0;

    case (st_reg.phase)
      SMP_IDLE, SMP_ADDR, SMP_DATA: begin
        if (phase_now != st_reg.phase) begin
          // A change of marker or select starts a fresh byte.
          st_next.phase = phase_now;
          st_next.bit_cnt = 3'h0;
          if (phase_now == SMP_IDLE) begin
            st_next.selected = 1'b0;
          end
        end else if (sck_rise && (st_reg.phase != SMP_IDLE)) begin
          st_next.shift_in = byte_now;
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        end
      end
      default: begin
        st_next.phase = SMP_IDLE;
        st_next.bit_cnt = 3'h0;
        st_next.selected = 1'b0;
      end
    endcase

    if (addr_done) begin
      st_next.selected = (byte_now == `SMP_MODULE_ADDR);
    end

    // The answer byte is loaded at a byte boundary and leaves on the following falling edges.
    if (addr_done || data_done) begin
      st_next.shift_out = {2'h0, st_reg.channel};
    end else if (sck_fall && st_reg.selected) begin
      st_next.miso = st_reg.shift_out[`SMP_BYTE_W-1];
      st_next.shift_out = {st_reg.shift_out[`SMP_BYTE_W-2:0], 1'b0};
    end
    st_next.miso_oe = st_next.selected;

    if (data_load) begin
      st_next.channel = byte_now[`SMP_CHAN_W-1:0];
    end else if (scan_rise) begin
      st_next.channel = chan_inc;
    end

    // The link cannot be stalled, so a byte that finds the holding slot still full is dropped and flagged.
    if (data_done) begin
      st_next.pend_valid = 1'b1;
      st_next.pend_data = byte_now;
      st_next.overrun = st_reg.pend_valid & ~buf_in_ready;
      if (st_reg.pend_valid & ~buf_in_ready) begin
        st_next.pend_data = st_reg.pend_data;
      end
    end else if (buf_in_ready) begin
      st_next.pend_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.sel_s1 <= 1'b1;
      st_reg.sel_s2 <= 1'b1;
      st_reg.phase <= SMP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  smp_buf #(
    .WIDTH(`SMP_BUF_W)
  ) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(st_reg.pend_valid),
    .in_ready(buf_in_ready),
    .in_data(st_reg.pend_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign serial_out_line = st_reg.miso;
  assign serial_out_oe = st_reg.miso_oe;
  assign channel_select = st_reg.channel;
  assign module_selected = st_reg.selected;
  assign rx_overrun = st_reg.overrun;

  AST_CHANNEL_ADVANCE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (scan_rise && !data_load) |=> (channel_select == $past(chan_inc)))
    else $error("Channel did not advance on a scan clock rising edge.");

  AST_CHANNEL_HOLD: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!scan_rise && !data_load) |=> $stable(channel_select))
    else $error("Channel moved without a scan clock edge or a load.");

  AST_CHANNEL_RANGE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    channel_select <= `SMP_CHAN_INPUTS)
    else $error("Channel index beyond the cold-junction source.");

  AST_WRAP_AFTER_CJ: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (channel_select == `SMP_CHAN_COLD_JUNCTION && scan_rise && !data_load) |=> (channel_select == `SMP_CHAN_FIRST))
    else $error("Sequence did not wrap after the cold-junction source.");

  AST_SAMPLE_ON_RISE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sck_rise && st_reg.phase != SMP_IDLE && phase_now == st_reg.phase)
      |=> (st_reg.shift_in[0] == $past(st_reg.mosi_s2)))
    else $error("Serial-in bit not captured on the rising serial clock edge.");

  AST_OUT_ON_FALL: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(serial_out_line) |-> $past(sck_fall))
    else $error("Serial-out changed away from a falling serial clock edge.");

  AST_SLOT0_IGNORED: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!st_reg.sel_s2) |=> (!module_selected && !serial_out_oe))
    else $error("Module stayed selected during slot zero traffic.");

  AST_ADDR_MATCH: assert property (
    @(posedge mclk) disable iff (!rst_n)
    addr_done |=> (module_selected == ($past(byte_now) == `SMP_MODULE_ADDR)))
    else $error("Address byte did not set the selection correctly.");

  AST_COUNT_ON_CLOCK: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_reg.bit_cnt != 3'h0 && $changed(st_reg.bit_cnt)) |-> $past(sck_rise))
    else $error("Bit counter moved without a serial clock edge.");

  AST_DATA_QUEUED: assert property (
    @(posedge mclk) disable iff (!rst_n)
    data_done |=> st_reg.pend_valid)
    else $error("Received data byte was not queued.");

  AST_RESTART_ON_PHASE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (phase_now != st_reg.phase) |=> (st_reg.bit_cnt == 3'h0))
    else $error("Bit count did not restart on a marker or select change.");

  COV_SCAN: cover property (@(posedge mclk) disable iff (!rst_n) scan_rise ##1 channel_select == 6'h01);
  COV_SELECT: cover property (@(posedge mclk) disable iff (!rst_n) addr_done ##1 module_selected);
  COV_DATA_OUT: cover property (@(posedge mclk) disable iff (!rst_n) data_done ##[1:40] rx_valid);
  COV_STALL: cover property (@(posedge mclk) disable iff (!rst_n) rx_valid && !rx_ready && !buf_in_ready);
  COV_SLOT0: cover property (@(posedge mclk) disable iff (!rst_n) !st_reg.sel_s2 && sck_rise);

endmodule

// file: smp_ctl_model.sv
// Behavioural acquisition controller that drives the serial link of the port.
`timescale 1ns/1ps
module smp_ctl_model (
  input wire logic mclk,
  input wire logic serial_out_line,
  output logic serial_in_line,
  output logic data_or_address_line,
  output logic slot_zero_select_n,
  output logic serial_shift_clock,
  output logic scan_advance_clock,
  output logic [7:0] answer
);
  initial begin
    serial_in_line = 1'b0;
    data_or_address_line = 1'b0;
    slot_zero_select_n = 1'b1;
    serial_shift_clock = 1'b0;
    scan_advance_clock = 1'b0;
    answer = 8'h00;
  end
  // The link clock stands low between frames; each half period is four cycles, 200 ns in all.
  // The answer is taken late in the high phase, where the port has long settled its output.
  task automatic xfer(input logic mark, input logic sel_n, input logic [7:0] b);
    data_or_address_line = mark;
    slot_zero_select_n = sel_n;
    for (int i = 7; i >= 0; i--) begin
      serial_in_line = b[i];
      repeat (4) @(negedge mclk);
      serial_shift_clock = 1'b1;
      repeat (4) @(negedge mclk);
      answer = {answer[6:0], serial_out_line};
      serial_shift_clock = 1'b0;
    end
    // A released data line must not keep showing the last bit.
    serial_in_line = ~b[0];
    repeat (12) @(negedge mclk);
  endtask
  task automatic scan();
    scan_advance_clock = 1'b1;
    repeat (4) @(negedge mclk);
    scan_advance_clock = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// file: testbench.sv
// Self-checking testbench of the serial host port.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, rx_ready, sin, sout, soe, dal, sel_n, sck, scan, sel, rx_valid, rx_overrun;
  logic [5:0] chan;
  logic [7:0] rx_data, answer;
  int bad_count, samples_checked, cycles, overruns;
  smp_ctl_model ctl (.mclk(mclk), .serial_out_line(sout), .serial_in_line(sin), .data_or_address_line(dal),
    .slot_zero_select_n(sel_n), .serial_shift_clock(sck), .scan_advance_clock(scan), .answer(answer));
  smp_port dut (.mclk(mclk), .rst_n(rst_n), .serial_in_line(sin), .serial_out_line(sout), .serial_out_oe(soe),
    .data_or_address_line(dal), .slot_zero_select_n(sel_n), .serial_shift_clock(sck),
    .scan_advance_clock(scan), .channel_select(chan), .module_selected(sel), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    cycles <= cycles + 1;
    if (rx_overrun === 1'b1) overruns <= overruns + 1;
    if (cycles == 8000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Takes one byte from the receive stream; the wait is bounded so a lost byte cannot hang the run.
  task automatic pop(input logic [7:0] exp);
    for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) @(negedge mclk);
    chk({7'h00, rx_valid}, 8'h01);
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_reset();
    chk({2'h0, chan}, 8'h00);
    chk({4'h0, sel, soe, rx_valid, rx_overrun}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_scan();
    repeat (3) ctl.scan();
    chk({2'h0, chan}, 8'h03);
    $display("test scan done");
  endtask
  task automatic t_address();
    ctl.xfer(1'b1, 1'b1, 8'h01);
    chk({6'h00, sel, soe}, 8'h03);
    ctl.xfer(1'b0, 1'b1, 8'h20);
    chk(answer, 8'h03);
    chk({2'h0, chan}, 8'h20);
    pop(8'h20);
    ctl.scan();
    chk({2'h0, chan}, 8'h00);
    $display("test address done");
  endtask
  task automatic t_slot_zero();
    ctl.xfer(1'b0, 1'b0, 8'h07);
    chk({6'h00, sel, rx_valid}, 8'h00);
    ctl.xfer(1'b1, 1'b1, 8'h02);
    ctl.xfer(1'b0, 1'b1, 8'h09);
    chk({6'h00, sel, rx_valid}, 8'h00);
    $display("test slot zero done");
  endtask
  task automatic t_stall();
    ctl.xfer(1'b1, 1'b1, 8'h01);
    for (int i = 1; i <= 4; i++) ctl.xfer(1'b0, 1'b1, 8'h20 + i[7:0]);
    chk(overruns[7:0], 8'h01);
    pop(8'h21);
    pop(8'h22);
    pop(8'h23);
    repeat (4) @(negedge mclk);
    chk({7'h00, rx_valid}, 8'h00);
    chk({2'h0, chan}, 8'h00);
    $display("test stall done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    rx_ready = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset();
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_scan();
    t_address();
    t_slot_zero();
    t_stall();
    complete_run();
  end
endmodule
